// file: hw/ucp_pkg.sv
package ucp_pkg;

    // Register indices on the three address inputs
    localparam logic [2:0] ADDR_MSR   = 3'h6;
    localparam logic [2:0] ADDR_MCR   = 3'h4;
    localparam logic [2:0] ADDR_EFR   = 3'h2;
    localparam logic [2:0] ADDR_LVL   = 3'h5;
    localparam logic [2:0] ADDR_IST   = 3'h0;
    localparam logic [2:0] ADDR_IMSK  = 3'h1;
    localparam logic [2:0] ADDR_TRIG  = 3'h3;
    localparam logic [2:0] ADDR_DIR   = 3'h7;

    // Field positions
    localparam int MCR_RTS_BIT    = 1;
    localparam int MCR_OUT_BIT    = 3;
    localparam int MCR_LOOP_BIT   = 4;
    localparam int EFR_ARTS_BIT   = 6;
    localparam int MSR_DRI_BIT    = 2;
    localparam int MSR_RI_BIT     = 6;
    localparam int IST_MODEM_BIT  = 0;
    localparam int IST_RXRDY_BIT  = 1;
    localparam int IST_TXRDY_BIT  = 2;

    // Reset values
    localparam logic [7:0] MCR_RST   = 8'h00;
    localparam logic [7:0] EFR_RST   = 8'h00;
    localparam logic [7:0] IMSK_RST  = 8'h00;
    localparam logic [7:0] TRIG_RST  = 8'h11;
    localparam logic [7:0] IST_RST   = 8'h00;

    // Depths
    localparam int FIFO_DEPTH = 64;

    // Receive FIFO condition, from the receive datapath
    typedef struct packed {
        logic [6:0] level;
        logic       err_present;
        logic       timeout;
    } ucp_rx_stat_s;

    // Host bus request after synchronisation
    typedef struct packed {
        logic       rd_n;
        logic       wr_n;
        logic       cs_n;
        logic [2:0] addr;
        logic [7:0] data;
    } ucp_bus_s;

endpackage

// file: hw/ucp_channel.sv
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
// How it works
// - Read strobe falling edge puts the addressed register on the data bus.
// - Write strobe rising edge stores bus data into the addressed register.
// - Control bit 3 set: interrupt driven, user output low; clear: tristate, high.
// - User output reads high after reset.
// - Reset returns all registers and outputs to their reset state.
// - Serial transmit and receive are held off while reset is applied.
// - Ring input mirrored in status; rising edge raises enabled modem interrupt.
// - Control bit 1 set drives request-to-send low, clear drives it high.
// - Request-to-send stays high after reset.
// - Request-to-send follows receive flow control only when feature bit 6 set.
// - Loopback ignores the receive pin and feeds transmit data to receiver.
// - Receive ready goes low at trigger level or on receive timeout.
// - Receive ready returns high when FIFO empties or holds an errored entry.
// - Transmit ready low with trigger-level spaces free, high when buffer full.
module ucp_channel #(
    parameter int FIFO_DEPTH = ucp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Host parallel bus pins
    input  wire logic                 read_strobe_n,
    input  wire logic                 write_strobe_n,
    input  wire logic                 channel_select_n,
    input  wire logic [2:0]           addr,
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic                      data_oe_n,
    // Modem and control pins
    input  wire logic                 ring_indicator_n,
    output logic                      request_to_send_n,
    output logic                      user_output_n,
    output logic                      channel_irq,
    output logic                      channel_irq_oe_n,
    // Serial datapath hooks
    input  wire logic                 serial_rx_pin,
    input  wire logic                 serial_tx_data,
    output logic                      serial_tx_pin,
    output logic                      receiver_in,
    // FIFO conditions from the datapath
    input  wire ucp_pkg::ucp_rx_stat_s rx_stat,
    input  wire logic [6:0]           tx_free,
    input  wire logic                 auto_rts_ready,
    // DMA handshake pins
    output logic                      rx_dma_ready_n,
    output logic                      tx_dma_ready_n
);

    // Pin synchronisers, two stages each
    logic [15:0] pin_s1_r;
    logic [15:0] pin_s2_r;
    logic        ri_prev_r;
    ucp_pkg::ucp_bus_s bus;
    logic        ri_n_s;
    logic        rx_pin_s;
    logic        rd_prev_r;
    logic        wr_prev_r;
    logic [7:0]  wr_data_r;
    logic [2:0]  wr_addr_r;
    logic        wr_cs_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r <= 16'hFFFF;
            pin_s2_r <= 16'hFFFF;
        end else begin
            pin_s1_r <= {serial_rx_pin, ring_indicator_n, read_strobe_n, write_strobe_n,
                         channel_select_n, addr, data_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Strobes, select, address and data fill the low 14 bits in struct order
    assign bus      = ucp_pkg::ucp_bus_s'(pin_s2_r[13:0]);
    assign ri_n_s   = pin_s2_r[14];
    assign rx_pin_s = pin_s2_r[15];

    // Registers
    logic [7:0] mcr_r;
    logic [7:0] efr_r;
    logic [7:0] imsk_r;
    logic [7:0] trig_r;
    logic [7:0] ist_r;
    logic [7:0] msr_delta_r;

    wire rd_fall  = rd_prev_r && !bus.rd_n && !bus.cs_n;
    wire wr_rise  = !wr_prev_r && bus.wr_n && wr_cs_r;
    wire ri_rise  = !ri_prev_r && ri_n_s;  // Pin low-to-high

    // Strobe edge trackers; write fields latched while strobe low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
            ri_prev_r <= 1'b1;
            wr_data_r <= 8'h00;
            wr_addr_r <= 3'h0;
            wr_cs_r   <= 1'b0;
        end else begin
            rd_prev_r <= bus.rd_n;
            wr_prev_r <= bus.wr_n;
            ri_prev_r <= ri_n_s;
            // Host keeps fields stable, so the last sample before the edge is taken
            if (!bus.wr_n) begin
                wr_data_r <= bus.data;
                wr_addr_r <= bus.addr;
                wr_cs_r   <= !bus.cs_n;
            end
        end
    end

    // Control register writes on the write strobe's rising edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mcr_r  <= ucp_pkg::MCR_RST;
            efr_r  <= ucp_pkg::EFR_RST;
            imsk_r <= ucp_pkg::IMSK_RST;
            trig_r <= ucp_pkg::TRIG_RST;
        end else if (wr_rise) begin
            case (wr_addr_r)
                ucp_pkg::ADDR_MCR:  mcr_r  <= wr_data_r;
                ucp_pkg::ADDR_EFR:  efr_r  <= wr_data_r;
                ucp_pkg::ADDR_IMSK: imsk_r <= wr_data_r;
                ucp_pkg::ADDR_TRIG: trig_r <= wr_data_r;
                default: ;
            endcase
        end
    end

    // Trigger levels: low nibble receive, high nibble transmit, in units of 4 bytes
    wire [6:0] rx_trig = (trig_r[3:0] == 4'h0) ? 7'h01 : {1'b0, trig_r[3:0], 2'b00};
    wire [6:0] tx_trig = (trig_r[7:4] == 4'h0) ? 7'h01 : {1'b0, trig_r[7:4], 2'b00};
    wire rx_hit  = (rx_stat.level >= rx_trig) || rx_stat.timeout;
    wire rx_stop = (rx_stat.level == 7'h00) || rx_stat.err_present;

    // Receive ready: set on trigger, released on empty or error
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_dma_ready_n <= 1'b1;
        end else if (rx_stop) begin
            rx_dma_ready_n <= 1'b1;
        end else if (rx_hit) begin
            rx_dma_ready_n <= 1'b0;
        end
    end

    // Transmit ready from free space
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_dma_ready_n <= 1'b1;
        end else if (tx_free == 7'h00) begin
            tx_dma_ready_n <= 1'b1;
        end else if (tx_free >= tx_trig) begin
            tx_dma_ready_n <= 1'b0;
        end
    end

    // Ring delta and interrupt status; a read clears, but a new event wins
    wire ist_read = rd_fall && (bus.addr == ucp_pkg::ADDR_IST);
    wire msr_read = rd_fall && (bus.addr == ucp_pkg::ADDR_MSR);
    logic [7:0] ist_set;
    assign ist_set = {5'h00, !tx_dma_ready_n, !rx_dma_ready_n, ri_rise};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ist_r       <= ucp_pkg::IST_RST;
            msr_delta_r <= 8'h00;
        end else begin
            ist_r <= (ist_read ? 8'h00 : ist_r) | ist_set;
            msr_delta_r[ucp_pkg::MSR_DRI_BIT] <=
                (msr_read ? 1'b0 : msr_delta_r[ucp_pkg::MSR_DRI_BIT]) | ri_rise;
        end
    end

    // Register read mux
    function automatic logic [7:0] rd_mux(input logic [2:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ucp_pkg::ADDR_MSR:  v = msr_delta_r | (8'(!ri_n_s) << ucp_pkg::MSR_RI_BIT);
            ucp_pkg::ADDR_MCR:  v = mcr_r;
            ucp_pkg::ADDR_EFR:  v = efr_r;
            ucp_pkg::ADDR_IMSK: v = imsk_r;
            ucp_pkg::ADDR_TRIG: v = trig_r;
            ucp_pkg::ADDR_IST:  v = ist_r;
            ucp_pkg::ADDR_LVL:  v = {1'b0, rx_stat.level};
            ucp_pkg::ADDR_DIR:  v = {1'b0, tx_free};
            default:            v = 8'h00;
        endcase
        return v;
    endfunction

    // Data bus drive from read strobe fall until strobe release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b1;
        end else if (rd_fall) begin
            data_out  <= rd_mux(bus.addr);
            data_oe_n <= 1'b0;
        end else if (bus.rd_n || bus.cs_n) begin
            data_oe_n <= 1'b1;
        end
    end

    // Modem pins and gated interrupt
    wire irq_any = |(ist_r & imsk_r);
    wire rts_on  = mcr_r[ucp_pkg::MCR_RTS_BIT] &&
                   (!efr_r[ucp_pkg::EFR_ARTS_BIT] || auto_rts_ready);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            request_to_send_n <= 1'b1;
            user_output_n     <= 1'b1;
            channel_irq       <= 1'b0;
            channel_irq_oe_n  <= 1'b1;
        end else begin
            request_to_send_n <= !rts_on;
            user_output_n     <= !mcr_r[ucp_pkg::MCR_OUT_BIT];
            channel_irq_oe_n  <= !mcr_r[ucp_pkg::MCR_OUT_BIT];
            channel_irq       <= irq_any;
        end
    end

    // Serial routing; reset holds line idle and receiver fed idle level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_tx_pin <= 1'b1;
            receiver_in   <= 1'b1;
        end else if (mcr_r[ucp_pkg::MCR_LOOP_BIT]) begin
            serial_tx_pin <= 1'b1;
            receiver_in   <= serial_tx_data;
        end else begin
            serial_tx_pin <= serial_tx_data;
            receiver_in   <= rx_pin_s;
        end
    end

endmodule

// file: bench/ucp_chk_props.sv
`timescale 1ns/10ps
module ucp_chk (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rstn,
    // Host bus and modem pins
    input wire logic                  read_strobe_n,
    input wire logic                  channel_select_n,
    input wire logic                  data_oe_n,
    input wire logic                  request_to_send_n,
    input wire logic                  user_output_n,
    input wire logic                  channel_irq_oe_n,
    // FIFO conditions and DMA pins
    input wire ucp_pkg::ucp_rx_stat_s rx_stat,
    input wire logic [6:0]            tx_free,
    input wire logic                  rx_dma_ready_n,
    input wire logic                  tx_dma_ready_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // A taken read, then the bus turning round
    sequence rd_go;
        $fell(read_strobe_n) && !channel_select_n;
    endsequence
    sequence oe_on;
        ##[1:4] !data_oe_n;
    endsequence
    rd_answer_a: assert property (rd_go |-> oe_on)
        else $error("read not answered");
    rd_release_a: assert property ((read_strobe_n || channel_select_n)[*5] |-> data_oe_n)
        else $error("bus driven without read");
    out_pair_a: assert property (user_output_n == channel_irq_oe_n)
        else $error("user output and irq enable disagree");
    rst_outs_a: assert property ($rose(rstn) |-> user_output_n && request_to_send_n)
        else $error("outputs not high after reset");
    rx_clear_a: assert property (rx_stat.level == 7'h00 || rx_stat.err_present
        |-> ##[1:2] rx_dma_ready_n) else $error("rx ready not released");
    rx_full_a: assert property (rx_stat.level == 7'h40 && !rx_stat.err_present
        |-> ##[1:2] !rx_dma_ready_n) else $error("rx ready not raised");
    tx_full_a: assert property (tx_free == 7'h00 |-> ##[1:2] tx_dma_ready_n)
        else $error("tx ready low when full");
    tx_empty_a: assert property (tx_free == 7'h40 |-> ##[1:2] !tx_dma_ready_n)
        else $error("tx ready high when empty");
endmodule

// file: bench/ucp_host.sv
`timescale 1ns/10ps
module ucp_host (
    // Clock and answer from the channel
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    // Host bus pins
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic            channel_select_n,
    output logic [2:0]      addr,
    output logic [7:0]      data_in
);
    // Bus idle with no access in flight
    initial begin
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        channel_select_n = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
    end
    // Strobe held three edges so the synchroniser sees it low at least twice
    task automatic wr(input logic sel_n, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        channel_select_n <= sel_n;
        addr <= a;
        data_in <= d;
        write_strobe_n <= 1'b0;
        repeat (3) @(posedge clk);
        write_strobe_n <= 1'b1;
        repeat (3) @(posedge clk);
        channel_select_n <= 1'b1;
        data_in <= ~d; // Released bus must not keep the old byte
        repeat (3) @(posedge clk);
    endtask
    // Read waits a bounded time for the turned-round bus
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        channel_select_n <= 1'b0;
        addr <= a;
        read_strobe_n <= 1'b0;
        for (n = 0; n < 9 && data_oe_n !== 1'b0; n++) @(posedge clk) #1;
        d = (data_oe_n === 1'b0) ? data_out : 8'hXX;
        @(posedge clk);
        read_strobe_n <= 1'b1;
        channel_select_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // Bench and host model drive these, the channel the rest
    logic                  clk, rstn, ring_indicator_n, serial_rx_pin, serial_tx_data;
    logic                  auto_rts_ready, read_strobe_n, write_strobe_n, channel_select_n;
    logic [6:0]            tx_free;
    ucp_pkg::ucp_rx_stat_s rx_stat;
    logic [2:0]            addr;
    logic [7:0]            data_in, data_out, d;
    logic                  data_oe_n, request_to_send_n, user_output_n, channel_irq;
    logic                  channel_irq_oe_n, serial_tx_pin, receiver_in;
    logic                  rx_dma_ready_n, tx_dma_ready_n;
    int                    err_total, n_checks, cyc;
    ucp_channel u_dut (.*);
    ucp_host u_host (.*);
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Enough edges for synchroniser, edge detect, status and output registers
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic t_rst();
        u_host.wr(1'b0, ucp_pkg::ADDR_MCR, 8'h0A);
        rstn <= 1'b0;
        settle();
        chk(request_to_send_n, 1'b1);
        chk(user_output_n, 1'b1);
        chk(serial_tx_pin, 1'b1);
        rstn <= 1'b1;
        u_host.rd(ucp_pkg::ADDR_TRIG, d);
        chk(d, ucp_pkg::TRIG_RST);
        $display("reset test done");
    endtask
    task automatic t_mcr();
        logic [7:0] v [4] = '{8'h0A, 8'h08, 8'h02, 8'h00};
        foreach (v[i]) begin
            u_host.wr(1'b0, ucp_pkg::ADDR_MCR, v[i]);
            chk(request_to_send_n, !v[i][1]);
            chk(channel_irq_oe_n, !v[i][3]);
            u_host.rd(ucp_pkg::ADDR_MCR, d);
            chk(d, v[i]);
        end
        u_host.wr(1'b1, ucp_pkg::ADDR_MCR, 8'h0A);
        chk(request_to_send_n, 1'b1);
        u_host.wr(1'b0, ucp_pkg::ADDR_EFR, 8'h40);
        u_host.wr(1'b0, ucp_pkg::ADDR_MCR, 8'h02);
        chk(request_to_send_n, 1'b1);
        auto_rts_ready <= 1'b1;
        settle();
        chk(request_to_send_n, 1'b0);
        $display("control test done");
    endtask
    task automatic t_lpb();
        u_host.wr(1'b0, ucp_pkg::ADDR_MCR, 8'h10);
        serial_tx_data <= 1'b1;
        serial_rx_pin <= 1'b0;
        settle();
        chk(receiver_in, 1'b1);
        u_host.wr(1'b0, ucp_pkg::ADDR_MCR, 8'h00);
        chk(receiver_in, 1'b0);
        $display("loopback test done");
    endtask
    task automatic t_ring();
        ring_indicator_n <= 1'b0;
        settle();
        u_host.rd(ucp_pkg::ADDR_MSR, d);
        chk(d[ucp_pkg::MSR_RI_BIT], 1'b1);
        ring_indicator_n <= 1'b1;
        settle();
        chk(channel_irq, 1'b0);
        u_host.wr(1'b0, ucp_pkg::ADDR_IMSK, 8'h01);
        chk(channel_irq, 1'b1);
        u_host.rd(ucp_pkg::ADDR_IST, d);
        chk(d[ucp_pkg::IST_MODEM_BIT], 1'b1);
        chk(channel_irq, 1'b0);
        $display("ring test done");
    endtask
    // Each entry: level, error, timeout, then the expected ready level
    task automatic t_dma();
        logic [9:0] t [6] = '{10'h019, 10'h020, 10'h001, 10'h012, 10'h015, 10'h200};
        foreach (t[i]) begin
            rx_stat <= t[i][9:1];
            settle();
            chk(rx_dma_ready_n, t[i][0]);
        end
        tx_free <= 7'h04;
        settle();
        chk(tx_dma_ready_n, 1'b0);
        tx_free <= 7'h00;
        settle();
        chk(tx_dma_ready_n, 1'b1);
        tx_free <= 7'h40;
        settle();
        chk(tx_dma_ready_n, 1'b0);
        $display("dma test done");
    endtask
    // Hang guard far above the roughly three hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        rstn = 1'b0;
        ring_indicator_n = 1'b1;
        serial_rx_pin = 1'b1;
        serial_tx_data = 1'b0;
        auto_rts_ready = 1'b0;
        tx_free = 7'h00;
        rx_stat = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_rst();
        t_mcr();
        t_lpb();
        t_ring();
        t_dma();
        wrap_up();
    end
endmodule
bind ucp_channel ucp_chk u_chk (.*);
